//--- dbrb_map.vh
/*
  constants of the bank, row and burst logic: register offsets, field
  positions, reset values, encodings and counts.
  assumes it is included by its bare name from each file that uses it.
*/
`ifndef DBRB_MAP_VH
`define DBRB_MAP_VH

// register byte offsets on the apb
`define DBRB_MODE_REGISTER_ZERO 12'h000
`define DBRB_MODE_REGISTER_ONE  12'h004
`define DBRB_TIMING             12'h008
`define DBRB_STATUS             12'h00C
`define DBRB_ERROR              12'h010

// mode register zero fields
`define DBRB_BLEN_LSB    0
`define DBRB_BLEN_MSB    1
`define DBRB_CASLAT_LSB  4
`define DBRB_CASLAT_MSB  7
`define DBRB_WRLAT_LSB   8
`define DBRB_WRLAT_MSB   11
`define DBRB_MODE_ZERO_RESET 32'h00000551

// mode register one fields
`define DBRB_DLL_BIT     0
`define DBRB_ADDLAT_LSB  3
`define DBRB_ADDLAT_MSB  4
`define DBRB_TERM_BIT    11
`define DBRB_MODE_ONE_RESET 32'h00000001

// timing register fields
`define DBRB_PREP_LSB    0
`define DBRB_PREP_MSB    7
`define DBRB_TIMING_RESET 32'h00000006

// status and error fields
`define DBRB_DLL_LOCK_BIT 24
`define DBRB_BUSY_BIT     25
`define DBRB_ERR_ILLEGAL  0
`define DBRB_ERR_STROBE   1
`define DBRB_ERR_UNLOCKED 2

// burst length field encodings
`define DBRB_BLEN_FIXED8 2'h0
`define DBRB_BLEN_OTF    2'h1
`define DBRB_BLEN_FIXED4 2'h2

// additive latency selections
`define DBRB_ADDLAT_ZERO  2'h0
`define DBRB_ADDLAT_MINUS1 2'h1
`define DBRB_ADDLAT_MINUS2 2'h2

// command codes {cs_n, ras_n, cas_n, we_n}
`define DBRB_CMD_ACTIVATE  4'h3
`define DBRB_CMD_READ      4'h5
`define DBRB_CMD_WRITE     4'h4
`define DBRB_CMD_PRECHARGE 4'h2

// bank states
`define DBRB_BANK_IDLE 2'h0
`define DBRB_BANK_OPEN 2'h1
`define DBRB_BANK_PREC 2'h2

// address bit positions and counts
`define DBRB_AUTO_PRE_BIT  10
`define DBRB_CHOP_BIT      12
`define DBRB_BEATS_LONG    4'h8
`define DBRB_BEATS_CHOP    4'h4
`define DBRB_PIPE_AW       5
`define DBRB_DLL_LOCK_NCK  512

`endif

//--- dbrb_sync.v
/*
  two flip-flop synchroniser for a vector of pin levels.
  assumes each bit is a level that stays put for several clocks.
*/
`timescale 1ns/100ps
module dbrb_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clock,
  input  wire             sys_rst,
  // pins and their synchronised copy
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stageOne;  // first stage, read only by the second

  // two stages, nothing but the second looks at the first
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stageOne <= {WIDTH{1'b0}};
      syncOut  <= {WIDTH{1'b0}};
    end else begin
      stageOne <= asyncIn;
      syncOut  <= stageOne;
    end
  end

endmodule // dbrb_sync

//--- dbrb_bank.v
/*
  state of one bank: idle, open with its row, or precharging.
  assumes the strobes are one-clock pulses taken on memory clock rises.
*/
`timescale 1ns/100ps
`include "dbrb_map.vh"
module dbrb_bank #(
  parameter ROW_WIDTH = 16
) (
  // clock and reset
  input  wire                 clock,
  input  wire                 sys_rst,
  // strobes from the command decoder
  input  wire                 ckRise,
  input  wire                 activate,
  input  wire                 precharge,
  input  wire [ROW_WIDTH-1:0] rowIn,
  input  wire [7:0]           prechargePeriod,
  // state out
  output reg  [1:0]           state,
  output reg  [ROW_WIDTH-1:0] openRow
);

  localparam [1:0] IDLE = `DBRB_BANK_IDLE;
  localparam [1:0] OPEN = `DBRB_BANK_OPEN;
  localparam [1:0] PREC = `DBRB_BANK_PREC;

  reg [7:0] preCount;  // memory clocks left of the precharge period

  // bank state machine
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= IDLE;
      openRow  <= {ROW_WIDTH{1'b0}};
      preCount <= 8'h00;
    end else if (precharge) begin
      // any precharge restarts the period, also on idle or precharging banks
      state    <= PREC;
      preCount <= prechargePeriod;
    end else if (activate && state == IDLE) begin
      state   <= OPEN;
      openRow <= rowIn;
    end else begin
      case (state)
        OPEN: state <= OPEN;
        PREC: begin
          // count the period, then the bank is idle
          if (ckRise) begin
            if (preCount <= 8'h01) begin
              state <= IDLE;
            end
            if (preCount != 8'h00) begin
              preCount <= preCount - 8'h01;
            end
          end
        end
        IDLE: state <= IDLE;
        default: state <= IDLE;
      endcase
    end
  end

endmodule // dbrb_bank

//--- dbrb_core.v
/*
  bank, row and burst logic of a synchronous dram device: command decode,
  bank state per bank, read and write bursts of eight or four beats, byte
  mask, output release, and the mode and status registers on apb.
  assumes the memory clock and all command pins are slow against clock,
  and that the apb master runs on clock.
*/
// Overview of operation
// - activate opens bank's addressed row
// - row stays open until bank precharged
// - precharge closes one bank or all
// - other bank accesses allowed during auto precharge
// - precharge on closed bank restarts period
// - chop bit picks four or eight beats
// - chop bit never part of column
// - eight beats when fixed eight or on the fly with chop high
// - release drive latency plus four or two
// - read data starts after read latency
// - read drive only with locked delay loop
// - data timing faults corrupt addressed word only
// - strobe faults never hang the device
// - one mask bit per data byte
// - mask ignored during reads
// - byte-wide mask becomes termination strobe
`timescale 1ns/100ps
`include "dbrb_map.vh"
module dbrb_core #(
  parameter ADDR_WIDTH   = 16,
  parameter DQ_WIDTH     = 16,
  parameter MEM_ROW_BITS = 2,
  parameter MEM_COL_BITS = 5,
  parameter DLL_LOCK_NCK = `DBRB_DLL_LOCK_NCK
) (
  // clock and reset
  input  wire                  clock,
  input  wire                  sys_rst,
  // apb slave
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [11:0]           paddr,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output wire                  pready,
  output reg                   pslverr,
  // command pins
  input  wire                  memClk,
  input  wire                  chipSelectN,
  input  wire                  rowStrobeN,
  input  wire                  colStrobeN,
  input  wire                  writeEnableN,
  input  wire [2:0]            bankSelectInputs,
  input  wire [ADDR_WIDTH-1:0] addrIn,
  // data and strobe pins
  input  wire [DQ_WIDTH-1:0]   dqIn,
  output reg  [DQ_WIDTH-1:0]   dqOut,
  output reg                   dqOe,
  input  wire                  dqsIn,
  output reg                   dqsOut,
  output reg                   dqsOe,
  input  wire [DQ_WIDTH/8-1:0] writeByteMask,
  output reg                   terminationStrobe
);

  localparam NB   = DQ_WIDTH / 8;
  localparam SW   = 8 + ADDR_WIDTH + DQ_WIDTH + 1 + NB;
  localparam MAW  = 3 + MEM_ROW_BITS + MEM_COL_BITS;
  localparam EW   = 6 + MEM_ROW_BITS + MEM_COL_BITS;
  localparam DEP  = 1 << `DBRB_PIPE_AW;
  localparam E_WR = EW - 1;
  localparam E_AP = EW - 2;
  localparam E_BC = EW - 3;
  localparam E_BK = MEM_ROW_BITS + MEM_COL_BITS;
  localparam E_RW = MEM_COL_BITS;
  localparam [15:0] LOCK_N = DLL_LOCK_NCK;

  // synchronised pins
  wire [SW-1:0]         pinSync;
  wire                  ckS   = pinSync[SW-1];
  wire [3:0]            cmdS  = pinSync[SW-2:SW-5];
  wire [2:0]            bankS = pinSync[SW-6:SW-8];
  wire [ADDR_WIDTH-1:0] addrS = pinSync[NB+1+DQ_WIDTH +: ADDR_WIDTH];
  wire [DQ_WIDTH-1:0]   dqS   = pinSync[NB+1 +: DQ_WIDTH];
  wire                  dqsS  = pinSync[NB];
  wire [NB-1:0]         maskS = pinSync[NB-1:0];

  dbrb_sync #(
    .WIDTH (SW)
  ) pinSyncer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .asyncIn ({memClk, chipSelectN, rowStrobeN, colStrobeN, writeEnableN,
               bankSelectInputs, addrIn, dqIn, dqsIn, writeByteMask}),
    .syncOut (pinSync)
  );

  // registers
  reg  [31:0] modeRegisterZero;  // burst length and latencies
  reg  [31:0] modeRegisterOne;   // delay loop, additive latency, strobe mode
  reg  [31:0] timingReg;         // precharge period in memory clocks
  reg  [2:0]  errFlags;          // sticky faults, write one to clear
  reg  [15:0] lockCount;         // memory clocks since the loop was enabled, held at LOCK_N
  reg         ckPrev;            // last memory clock level

  // memory clock edges
  wire ckRise = ckS & ~ckPrev;
  wire ckFall = ~ckS & ckPrev;
  wire ckEdge = ckRise | ckFall;

  // mode fields
  wire [1:0] blenField      = modeRegisterZero[`DBRB_BLEN_MSB:`DBRB_BLEN_LSB];
  wire [3:0] casLatency     = modeRegisterZero[`DBRB_CASLAT_MSB:`DBRB_CASLAT_LSB];
  wire [3:0] wrLatency      = modeRegisterZero[`DBRB_WRLAT_MSB:`DBRB_WRLAT_LSB];
  wire [1:0] addLatSel      = modeRegisterOne[`DBRB_ADDLAT_MSB:`DBRB_ADDLAT_LSB];
  wire       dllEnable      = modeRegisterOne[`DBRB_DLL_BIT];
  wire       termMode       = modeRegisterOne[`DBRB_TERM_BIT] && (DQ_WIDTH == 8);
  wire [7:0] prechargePeriod = timingReg[`DBRB_PREP_MSB:`DBRB_PREP_LSB];
  wire       dllLocked      = dllEnable && (lockCount == LOCK_N);

  reg  [3:0] additiveLatency;  // selected additive latency
  // additive latency from its selection
  always @* begin
    case (addLatSel)
      `DBRB_ADDLAT_MINUS1: additiveLatency = casLatency - 4'h1;
      `DBRB_ADDLAT_MINUS2: additiveLatency = casLatency - 4'h2;
      default:             additiveLatency = 4'h0;
    endcase
  end

  wire [4:0] readLatency  = {1'b0, additiveLatency} + {1'b0, casLatency};
  wire [4:0] writeLatency = {1'b0, additiveLatency} + {1'b0, wrLatency};

  // command decode
  wire cmdAct = ckRise && (cmdS == `DBRB_CMD_ACTIVATE);
  wire cmdRd  = ckRise && (cmdS == `DBRB_CMD_READ);
  wire cmdWr  = ckRise && (cmdS == `DBRB_CMD_WRITE);
  wire cmdPre = ckRise && (cmdS == `DBRB_CMD_PRECHARGE);
  wire autoPre         = addrS[`DBRB_AUTO_PRE_BIT];
  wire burstChopSelect = addrS[`DBRB_CHOP_BIT];

  // length per command: fixed field or chop bit on the fly
  wire chopNow = (blenField == `DBRB_BLEN_FIXED4) ||
                 ((blenField == `DBRB_BLEN_OTF) && !burstChopSelect);

  // bank states, one per bank
  wire [15:0]             bankStates;
  wire [8*ADDR_WIDTH-1:0] bankRows;
  reg                     apFire;     // burst end closes burstBank one clock later, the next burst's bank if one starts on that edge
  reg  [2:0]              burstBank;  // bank of the running burst

  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : bankGen
      dbrb_bank #(
        .ROW_WIDTH (ADDR_WIDTH)
      ) bankState (
        .clock           (clock),
        .sys_rst         (sys_rst),
        .ckRise          (ckRise),
        .activate        (cmdAct && bankS == b),
        .precharge       ((cmdPre && (autoPre || bankS == b)) ||
                          (apFire && burstBank == b)),
        .rowIn           (addrS),
        .prechargePeriod (prechargePeriod),
        .state           (bankStates[2*b +: 2]),
        .openRow         (bankRows[ADDR_WIDTH*b +: ADDR_WIDTH])
      );
    end
  endgenerate

  wire [1:0]            selState = bankStates[2*bankS +: 2];
  wire [ADDR_WIDTH-1:0] selRow   = bankRows[ADDR_WIDTH*bankS +: ADDR_WIDTH];

  // faults against the bank state of the addressed bank only
  wire illegalCmd = (cmdAct && selState != `DBRB_BANK_IDLE) ||
                    ((cmdRd || cmdWr) && selState != `DBRB_BANK_OPEN);

  // latency pipe: one slot per memory clock, column bits below the chop bit
  reg [EW-1:0]             pipeMem [0:DEP-1];  // queued column commands
  reg [DEP-1:0]            pipeValid;          // slot holds a command
  reg [`DBRB_PIPE_AW-1:0]  pipePtr;            // slot written next

  wire [EW-1:0] newEntry = {cmdWr, autoPre, chopNow, bankS, selRow[MEM_ROW_BITS-1:0],
                            addrS[MEM_COL_BITS-1:0]};
  wire [`DBRB_PIPE_AW-1:0] rdTap = pipePtr - readLatency;
  wire [`DBRB_PIPE_AW-1:0] wrTap = pipePtr - writeLatency;
  wire rdHit  = pipeValid[rdTap] && !pipeMem[rdTap][E_WR];
  wire wrHit  = pipeValid[wrTap] && pipeMem[wrTap][E_WR];
  wire start  = ckRise && (rdHit || wrHit);
  wire [EW-1:0] tapEntry = rdHit ? pipeMem[rdTap] : pipeMem[wrTap];

  // pipe fill on each memory clock rise
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pipeValid <= {DEP{1'b0}};
      pipePtr   <= {`DBRB_PIPE_AW{1'b0}};
    end else if (ckRise) begin
      pipeValid[pipePtr] <= (cmdRd || cmdWr) && !illegalCmd;
      pipePtr            <= pipePtr + 1'b1;
    end
  end

  // pipe contents
  always @(posedge clock) begin
    if (ckRise) begin
      pipeMem[pipePtr] <= newEntry;
    end
  end

  // running burst
  reg                    burstAct;   // burst in progress
  reg                    burstWr;    // burst is a write
  reg                    burstAp;    // close bank at burst end
  reg                    burstChop;  // four beats
  reg [MEM_ROW_BITS-1:0] burstRow;   // low row bits
  reg [MEM_COL_BITS-1:0] burstCol;   // start column
  reg [3:0]              beat;       // next beat index
  reg                    lastDqs;    // strobe level at the last write beat

  wire [3:0] burstLen = burstChop ? `DBRB_BEATS_CHOP : `DBRB_BEATS_LONG;
  wire       ending   = burstAct && ckEdge && (beat == burstLen);
  wire       doBeat   = start || (burstAct && ckEdge && beat != burstLen);

  // current beat fields, from the tap on a start
  wire                    curWr   = start ? tapEntry[E_WR] : burstWr;
  wire                    curChop = start ? tapEntry[E_BC] : burstChop;
  wire [2:0]              curBank = start ? tapEntry[E_BK +: 3] : burstBank;
  wire [MEM_ROW_BITS-1:0] curRow  = start ? tapEntry[E_RW +: MEM_ROW_BITS] : burstRow;
  wire [MEM_COL_BITS-1:0] curCol  = start ? tapEntry[MEM_COL_BITS-1:0] : burstCol;
  wire [3:0]              curBeat = start ? 4'h0 : beat;

  // sequential order in the burst, chop stays inside its nibble
  wire [2:0] lowCol = curChop ? {curCol[2], curCol[1:0] + curBeat[1:0]}
                              : curCol[2:0] + curBeat[2:0];
  wire [MAW-1:0] memAddr = {curBank, curRow, curCol[MEM_COL_BITS-1:3], lowCol};

  // storage and byte merge
  reg  [DQ_WIDTH-1:0] memArray [0:(1<<MAW)-1];  // data words
  wire [DQ_WIDTH-1:0] memRd = memArray[memAddr];
  wire [DQ_WIDTH-1:0] merged;

  genvar y;
  generate
    for (y = 0; y < NB; y = y + 1) begin : byteGen
      // mask bit keeps the old byte unless it acts as termination strobe
      assign merged[8*y +: 8] = (maskS[y] && !termMode) ? memRd[8*y +: 8] : dqS[8*y +: 8];
    end
  endgenerate

  // write beats into the addressed word only
  always @(posedge clock) begin
    if (doBeat && curWr) begin
      memArray[memAddr] <= merged;
    end
  end

  wire strobeFault = doBeat && curWr && curBeat != 4'h0 && dqsS == lastDqs;
  wire lockFault   = doBeat && !curWr && !dllLocked;

  // burst engine and pin drive
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      burstAct          <= 1'b0;
      burstWr           <= 1'b0;
      burstAp           <= 1'b0;
      burstChop         <= 1'b0;
      burstBank         <= 3'h0;
      burstRow          <= {MEM_ROW_BITS{1'b0}};
      burstCol          <= {MEM_COL_BITS{1'b0}};
      beat              <= 4'h0;
      lastDqs           <= 1'b0;
      apFire            <= 1'b0;
      dqOut             <= {DQ_WIDTH{1'b0}};
      dqOe              <= 1'b0;
      dqsOut            <= 1'b0;
      dqsOe             <= 1'b0;
      terminationStrobe <= 1'b0;
    end else begin
      apFire <= ending && burstAp;
      if (start) begin
        // a new burst may follow the last seamlessly
        burstAct  <= 1'b1;
        burstWr   <= tapEntry[E_WR];
        burstAp   <= tapEntry[E_AP];
        burstChop <= tapEntry[E_BC];
        burstBank <= curBank;
        burstRow  <= curRow;
        burstCol  <= curCol;
        beat      <= 4'h1;
      end else if (ending) begin
        // release strobe and data at the end of the last beat
        burstAct <= 1'b0;
        dqOe     <= 1'b0;
        dqsOe    <= 1'b0;
      end else if (doBeat) begin
        beat <= beat + 4'h1;
      end
      if (doBeat && !curWr) begin
        // read beat from the first edge after the read latency
        dqOut  <= memRd;
        dqOe   <= dllLocked;
        dqsOut <= ~curBeat[0];
        dqsOe  <= dllLocked;
      end else if (doBeat) begin
        // write beat: pins stay released
        lastDqs <= dqsS;
        dqOe    <= 1'b0;
        dqsOe   <= 1'b0;
      end
      terminationStrobe <= termMode && burstAct && burstWr;
    end
  end

  // delay loop lock count in memory clocks
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lockCount <= 16'h0000;
      ckPrev    <= 1'b0;
    end else begin
      ckPrev <= ckS;
      if (!dllEnable) begin
        lockCount <= 16'h0000;
      end else if (ckRise && lockCount != LOCK_N) begin
        lockCount <= lockCount + 16'h0001;
      end
    end
  end

  // apb decode
  wire apbWrite  = psel && penable && pwrite;
  wire apbSetup  = psel && !penable;
  wire hitZero   = paddr == `DBRB_MODE_REGISTER_ZERO;
  wire hitOne    = paddr == `DBRB_MODE_REGISTER_ONE;
  wire hitTiming = paddr == `DBRB_TIMING;
  wire hitStatus = paddr == `DBRB_STATUS;
  wire hitError  = paddr == `DBRB_ERROR;
  wire mapped    = hitZero || hitOne || hitTiming || hitStatus || hitError;
  wire [2:0] errSet = {lockFault, strobeFault, illegalCmd};
  wire [2:0] errClr = (apbWrite && hitError) ? pwdata[2:0] : 3'h0;

  assign pready = 1'b1;

  // register writes, sticky faults with set over clear
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      modeRegisterZero <= `DBRB_MODE_ZERO_RESET;
      modeRegisterOne  <= `DBRB_MODE_ONE_RESET;
      timingReg        <= `DBRB_TIMING_RESET;
      errFlags         <= 3'h0;
    end else begin
      if (apbWrite && hitZero) begin
        modeRegisterZero <= {20'h00000, pwdata[11:0]};
      end
      if (apbWrite && hitOne) begin
        modeRegisterOne <= {20'h00000, pwdata[11:0]};
      end
      if (apbWrite && hitTiming) begin
        timingReg <= {24'h000000, pwdata[7:0]};
      end
      errFlags <= (errFlags & ~errClr) | errSet;
    end
  end

  // read data and error taken in the setup cycle, shown in the access cycle
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apbSetup) begin
      pslverr <= !mapped;
      if (pwrite || !mapped) begin
        prdata <= 32'h00000000;
      end else if (hitZero) begin
        prdata <= modeRegisterZero;
      end else if (hitOne) begin
        prdata <= modeRegisterOne;
      end else if (hitTiming) begin
        prdata <= timingReg;
      end else if (hitStatus) begin
        prdata <= {6'h00, burstAct, dllLocked, 8'h00, bankStates};
      end else begin
        prdata <= {29'h00000000, errFlags};
      end
    end
  end

endmodule // dbrb_core

//--- dbrb_core_sva.sv
/* port checker of dbrb_core: apb answer, read drive window, mask pin.
   assumes it is bound onto dbrb_core and sees only its ports */
`timescale 1ns/100ps
module dbrb_core_sva #(
  parameter DQ_WIDTH = 16
) (
  // clock, reset and apb
  input wire logic                clock,
  input wire logic                sys_rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [11:0]         paddr,
  input wire logic                pready,
  input wire logic                pslverr,
  // data and strobe pins
  input wire logic [DQ_WIDTH-1:0] dqOut,
  input wire logic                dqOe,
  input wire logic                dqsOut,
  input wire logic                dqsOe,
  input wire logic                terminationStrobe
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (sys_rst);
  // apb answers at once, errors above the map, none on aligned offsets in it
  ready_now_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr) else $error("no slave error");
  mapped_ok_a: assert property (psel && penable && paddr <= 12'h010 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("false slave error");
  // read drive window
  oe_pair_a: assert property (dqOe == dqsOe) else $error("enables differ");
  first_beat_a: assert property ($rose(dqsOe) |-> dqsOut) else $error("first beat strobe low");
  burst_min_a: assert property ($rose(dqOe) |-> dqOe [*8]) else $error("burst too short");
  burst_end_a: assert property ($rose(dqOe) |-> ##[12:40] !dqOe) else $error("drive not released");
  beat_hold_a: assert property (dqOe && $past(dqOe) && $stable(dqsOut) |-> $stable(dqOut)) else $error("beat moved");
  // sixteen bit part never turns the mask pin round
  term_off_a: assert property (!terminationStrobe) else $error("termination strobe on wide part");
endmodule // dbrb_core_sva
bind dbrb_core dbrb_core_sva #(.DQ_WIDTH(DQ_WIDTH)) i_sva (.clock(clock), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .dqOut(dqOut), .dqOe(dqOe),
  .dqsOut(dqsOut), .dqsOe(dqsOe), .terminationStrobe(terminationStrobe));

//--- dbrb_ctl_model.sv
/* memory controller model: free running memory clock, commands, write beats.
   assumes write latency 5 and additive latency 0 in the device */
`timescale 1ns/100ps
`include "dbrb_map.vh"
module dbrb_ctl_model (
  // memory clock and command pins
  output logic        memClk,
  output logic        chipSelectN,
  output logic        rowStrobeN,
  output logic        colStrobeN,
  output logic        writeEnableN,
  output logic [2:0]  bankSelectInputs,
  output logic [15:0] addrIn,
  // write data, strobe and mask
  output logic [15:0] dqIn,
  output logic        dqsIn,
  output logic [1:0]  writeByteMask
);
  // idle pins, clock unrelated in phase to the system clock
  initial begin
    memClk = 1'b0;
    {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = 4'hF;
    bankSelectInputs = 3'h0;
    addrIn = 16'h0;
    dqIn = 16'h0;
    dqsIn = 1'b0;
    writeByteMask = 2'h0;
    #5.3 forever #16 memClk = ~memClk;
  end
  // one command for one memory clock, then released pins show inverted junk
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
    @(negedge memClk);
    {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} <= c;
    bankSelectInputs <= b;
    addrIn <= a;
    @(negedge memClk);
    {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} <= 4'hF;
    bankSelectInputs <= ~b;
    addrIn <= ~a;
  endtask
  // write burst, beats centred on memory clock edges, strobe may stick low
  task automatic wr(input logic [2:0] b, input logic [15:0] a, input logic [127:0] d, input logic [15:0] m,
                    input logic stuck);
    int n;
    n = a[`DBRB_CHOP_BIT] ? 8 : 4;
    cmd(`DBRB_CMD_WRITE, b, a);
    repeat (4) @(negedge memClk);
    for (int k = 0; k < n; k++) begin
      #8 dqIn <= d[16*k +: 16];
      writeByteMask <= m[2*k +: 2];
      dqsIn <= !stuck && !k[0];
      #8;
    end
    #8 dqIn <= ~dqIn;
    writeByteMask <= ~writeByteMask;
    dqsIn <= 1'b0;
  endtask
endmodule // dbrb_ctl_model

//--- dbrb_core_tb.sv
/* self-checking bench of dbrb_core: apb master, controller model, beat monitor.
   assumes a 4 ns clock and a lock count of four memory clocks */
`timescale 1ns/100ps
`include "dbrb_map.vh"
module dbrb_core_tb;
  logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, dqOe, dqsOe, dqsOut, termStrobe, er;
  logic memClk, chipSelectN, rowStrobeN, colStrobeN, writeEnableN, dqsIn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, seed;
  logic [2:0] bankSelectInputs;
  logic [15:0] addrIn, dqIn, dqOut, m;
  logic [1:0] writeByteMask;
  logic [127:0] d1, d2, e;
  logic [15:0] expQ[$];
  logic prevOe = 1'b0;
  logic prevDqs = 1'b0;
  int badCount = 0;
  int checksDone = 0;
  dbrb_core #(.DLL_LOCK_NCK(4)) i_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .memClk(memClk), .chipSelectN(chipSelectN), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
    .writeEnableN(writeEnableN), .bankSelectInputs(bankSelectInputs), .addrIn(addrIn), .dqIn(dqIn),
    .dqOut(dqOut), .dqOe(dqOe), .dqsIn(dqsIn), .dqsOut(dqsOut), .dqsOe(dqsOe), .writeByteMask(writeByteMask),
    .terminationStrobe(termStrobe));
  dbrb_ctl_model i_ctl (.memClk(memClk), .chipSelectN(chipSelectN), .rowStrobeN(rowStrobeN),
    .colStrobeN(colStrobeN), .writeEnableN(writeEnableN), .bankSelectInputs(bankSelectInputs),
    .addrIn(addrIn), .dqIn(dqIn), .dqsIn(dqsIn), .writeByteMask(writeByteMask));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checksDone++;
    if (g !== x) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk("prdata", x, r);
    chk("pslverr", {31'h0, xe}, {31'h0, er});
  endtask
  // read burst: note beats, wait bounded until all seen and drive released
  task automatic rd(input logic [2:0] b, input logic [15:0] a, input logic [127:0] d);
    for (int k = 0; k < (a[`DBRB_CHOP_BIT] ? 8 : 4); k++) expQ.push_back(d[16*k +: 16]);
    i_ctl.cmd(`DBRB_CMD_READ, b, a);
    for (int t = 0; t < 400 && (expQ.size() > 0 || dqOe !== 1'b0); t++) @(posedge clock);
    chk("beats left", 32'h0, expQ.size());
  endtask
  // beat monitor: a new beat is a strobe change while driving
  always @(posedge clock) begin
    prevOe <= dqOe;
    prevDqs <= dqsOut;
    if (dqOe === 1'b1 && (!prevOe || dqsOut !== prevDqs)) begin
      if (expQ.size() == 0)
        chk("extra beat", 32'h0, 32'h1);
      else
        chk("read beat", {16'h0, expQ.pop_front()}, {16'h0, dqOut});
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    badCount++;
    results;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sys_rst, seed} = {3'h0, 12'h0, 32'h0, 1'b1, 32'hA14F01CE};
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    rchk(`DBRB_MODE_REGISTER_ZERO, `DBRB_MODE_ZERO_RESET, 1'b0);
    rchk(`DBRB_MODE_REGISTER_ONE, `DBRB_MODE_ONE_RESET, 1'b0);
    rchk(`DBRB_TIMING, `DBRB_TIMING_RESET, 1'b0);
    rchk(12'h020, 32'h0, 1'b1);
    apb(1'b1, `DBRB_TIMING, 32'h3);
    repeat (64) @(posedge clock); // four lock rises at eight clocks each, with margin
    $display("registers done");
    i_ctl.cmd(`DBRB_CMD_ACTIVATE, 3'h2, 16'h0001);
    rchk(`DBRB_STATUS, 32'h01000010, 1'b0);
    d1 = {$random(seed), $random(seed), $random(seed), $random(seed)};
    d2 = {$random(seed), $random(seed), $random(seed), $random(seed)};
    m = $random(seed);
    for (int i = 0; i < 16; i++) e[8*i +: 8] = m[i] ? d1[8*i +: 8] : d2[8*i +: 8];
    i_ctl.wr(3'h2, 16'h1008, d1, 16'h0, 1'b0);
    i_ctl.wr(3'h2, 16'h1008, d2, m, 1'b0);
    rd(3'h2, 16'h1008, e);
    rd(3'h2, 16'h000C, e >> 64);
    $display("bursts done");
    i_ctl.wr(3'h2, 16'h1010, d1, 16'h0, 1'b1);
    rchk(`DBRB_ERROR, 32'h2, 1'b0);
    apb(1'b1, `DBRB_ERROR, 32'h2);
    rd(3'h2, 16'h1008, e);
    $display("strobe fault done");
    i_ctl.cmd(`DBRB_CMD_PRECHARGE, 3'h2, 16'h0);
    rchk(`DBRB_STATUS, 32'h01000020, 1'b0);
    repeat (60) @(posedge clock);
    rchk(`DBRB_STATUS, 32'h01000000, 1'b0);
    i_ctl.cmd(`DBRB_CMD_READ, 3'h2, 16'h1008);
    repeat (80) @(posedge clock);
    rchk(`DBRB_ERROR, 32'h1, 1'b0);
    apb(1'b1, `DBRB_ERROR, 32'h1);
    i_ctl.cmd(`DBRB_CMD_PRECHARGE, 3'h2, 16'h0);
    rchk(`DBRB_STATUS, 32'h01000020, 1'b0);
    i_ctl.cmd(`DBRB_CMD_PRECHARGE, 3'h0, 16'h0400);
    rchk(`DBRB_STATUS, 32'h0100AAAA, 1'b0);
    $display("precharge done");
    results;
  end
endmodule // dbrb_core_tb
